// [common/ssc_pkg.sv]
// shared constants and types for the single-shunt current reconstruction
package ssc_pkg;
    localparam int DUTY_W = 16;
    localparam int ADC_W = 12;
    localparam int CUR_W = 16;

    // timer clock period; the timer counts on clk, so cycles are counts
    localparam int CLK_PERIOD_NS = 8;
    // settle and sample times are board dependent: plain defaults
    localparam int SETTLE_NS = 600;
    localparam int ADC_SAMPLE_NS = 400;
    localparam int DEAD_TIME_NS = 1000;
    localparam int SETTLE_MARGIN_CYC =
        (SETTLE_NS + ADC_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_TIME_CYC =
        (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] SETTLE_MARGIN = 16'(SETTLE_MARGIN_CYC);
    localparam logic [16:0] MIN_WINDOW =
        17'(SETTLE_MARGIN_CYC + DEAD_TIME_CYC);

    // mid-scale code means zero bus current
    localparam logic [11:0] ADC_MID = 12'h800;
    localparam int ADC_FULL_SCALE_LOG2 = 12;

    // current_scale_factor: 5 V / (4096 * 0.1 ohm * gain 5), in mA per code
    localparam int ADC_SPAN_MV = 5000;
    localparam int SHUNT_MOHM = 100;
    localparam int AMP_GAIN = 5;
    localparam int SCALE_MUL = ADC_SPAN_MV * 1000 / (SHUNT_MOHM * AMP_GAIN);
    localparam int SCALE_SHIFT = ADC_FULL_SCALE_LOG2;

    // bus voltage channel: 0..50 V across the 0..5 V input span
    localparam int VBUS_FULL_MV = 50000;

    // offset averaging at start-up
    localparam int CALIB_LOG2 = 4;
    localparam logic [3:0] CALIB_LAST = 4'hF;

    typedef enum logic [5:0] {
        CASE_UVW = 6'h01,
        CASE_UWV = 6'h02,
        CASE_WUV = 6'h04,
        CASE_VUW = 6'h08,
        CASE_VWU = 6'h10,
        CASE_WVU = 6'h20
    } ssc_case_t;

    typedef enum logic [1:0] {
        MODE_CALIB = 2'h1,
        MODE_RUN = 2'h2
    } ssc_mode_t;
endpackage

// [logic/ssc_current_scale.sv]
// scales one signed offset-corrected shunt difference into milliamperes
module ssc_current_scale (
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic signed [13:0] codeDiff,
    output logic signed [15:0] currentMa,
    output logic loaded
);
    logic signed [29:0] product;
    logic signed [29:0] shifted;
    logic signed [15:0] currentMa_reg, currentMa_next;
    logic loaded_reg, loaded_next;

    always_comb begin
        product = 30'(codeDiff) * $signed(30'(ssc_pkg::SCALE_MUL));
        shifted = product >>> ssc_pkg::SCALE_SHIFT;
        // without a load the last value is held
        currentMa_next = load ? shifted[15:0] : currentMa_reg;
        loaded_next = load;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            currentMa_reg <= 16'sh0000;
            loaded_reg <= 1'b0;
        end else begin
            currentMa_reg <= currentMa_next;
            loaded_reg <= loaded_next;
        end
    end

    assign currentMa = currentMa_reg;
    assign loaded = loaded_reg;
endmodule

// [logic/ssc_current_reconstruction.sv]
// single-shunt phase current reconstruction, trigger placement, output disable
// Summary of operation
// - one low switch on: sample is its phase
// - two low switches on: negated third phase
// - sample only after settle plus sample margin
// - one 12-bit input, two result registers
// - conversions started by timer compare matches
// - third phase is negative sum of two
// - u>v>w: A=v+m, B=w+m, u and w
// - u>w>v: A=w+m, B=v+m, u and v
// - w>u>v: A=u+m, B=v+m, w and v
// - v>u>w: A=u+m, B=w+m, u and w
// - v>w>u: A=w+m, B=u+m, v and u
// - w>v>u: A=v+m, B=u+m, w and u
// - order duties each period, keep case flag
// - mid-scale code means zero current
// - current is code minus offset times factor
// - 0.1 ohm shunt, gain 5, five amperes
// - bus voltage 0..50 V over input span
// - overcurrent line forces PWM pins off immediately
// - oscillator stop also forces PWM pins off
// - output disable raises an interrupt request
// - offset captured once at start-up
// - flag periods where reading is impossible
// - assign currents once per period at trough
module ssc_current_reconstruction (
    input wire logic clk,
    input wire logic srst,
    input wire logic periodStart,
    input wire logic carrierTrough,
    input wire logic [15:0] timerCount,
    input wire logic [15:0] phaseUCompareLevel,
    input wire logic [15:0] phaseVCompareLevel,
    input wire logic [15:0] phaseWCompareLevel,
    input wire logic adcDone,
    input wire logic [11:0] adcData,
    input wire logic busVoltageDone,
    input wire logic [11:0] busVoltageData,
    input wire logic [5:0] pwmDriveEnable,
    input wire logic overcurrentDisableInputN,
    input wire logic oscillatorStopped,
    input wire logic outputDisableClear,
    output logic [15:0] sampleTriggerACompare,
    output logic [15:0] sampleTriggerBCompare,
    output logic adcTriggerA,
    output logic adcTriggerB,
    output logic [11:0] shuntResultFirst,
    output logic [11:0] shuntResultSecond,
    output logic [5:0] caseFlag,
    output logic notReadable,
    output logic offsetValid,
    output logic [11:0] shuntOffset,
    output logic signed [15:0] phaseUCurrentMa,
    output logic signed [15:0] phaseVCurrentMa,
    output logic signed [15:0] phaseWCurrentMa,
    output logic currentsValid,
    output logic [15:0] busVoltageMv,
    output logic [5:0] pwmOutputEnable,
    output logic outputDisableIrq
);
    // ordering of the three compare levels
    logic uGtV, uGtW, vGtW;
    ssc_pkg::ssc_case_t orderCase;
    logic [15:0] maxLvl, midLvl, minLvl;
    logic [16:0] upperGap, lowerGap;
    logic readable;

    // period and trigger group
    ssc_pkg::ssc_case_t caseReg, caseNext;
    logic [15:0] cmpAReg, cmpANext, cmpBReg, cmpBNext;
    logic notReadableReg, notReadableNext;
    logic armAReg, armANext, armBReg, armBNext;
    logic trigAReg, trigANext, trigBReg, trigBNext;
    logic tagBReg, tagBNext;

    // sample capture and offset group
    ssc_pkg::ssc_mode_t modeReg, modeNext;
    logic [11:0] firstReg, firstNext, secondReg, secondNext;
    logic gotAReg, gotANext, gotBReg, gotBNext;
    logic [15:0] calibSumReg, calibSumNext;
    logic [3:0] calibCntReg, calibCntNext;
    logic [11:0] offsetReg, offsetNext;

    // phase assignment
    logic commit;
    logic signed [13:0] diffA, diffB, diffThird;
    logic signed [13:0] uDiff, vDiff, wDiff;

    // output disable and bus voltage
    logic latchReg, latchNext;
    logic forceOff;
    logic [27:0] busProd;
    logic [15:0] busReg, busNext;

    always_comb begin
        uGtV = phaseUCompareLevel > phaseVCompareLevel;
        uGtW = phaseUCompareLevel > phaseWCompareLevel;
        vGtW = phaseVCompareLevel > phaseWCompareLevel;
        // equal levels land in a neighbouring case; the gap check flags them
        if (uGtV && vGtW) begin
            orderCase = ssc_pkg::CASE_UVW;
        end else if (uGtW && !vGtW) begin
            orderCase = ssc_pkg::CASE_UWV;
        end else if (!uGtW && uGtV) begin
            orderCase = ssc_pkg::CASE_WUV;
        end else if (!uGtV && uGtW) begin
            orderCase = ssc_pkg::CASE_VUW;
        end else if (vGtW) begin
            orderCase = ssc_pkg::CASE_VWU;
        end else begin
            orderCase = ssc_pkg::CASE_WVU;
        end
        case (orderCase)
            ssc_pkg::CASE_UVW: begin
                maxLvl = phaseUCompareLevel;
                midLvl = phaseVCompareLevel;
                minLvl = phaseWCompareLevel;
            end
            ssc_pkg::CASE_UWV: begin
                maxLvl = phaseUCompareLevel;
                midLvl = phaseWCompareLevel;
                minLvl = phaseVCompareLevel;
            end
            ssc_pkg::CASE_WUV: begin
                maxLvl = phaseWCompareLevel;
                midLvl = phaseUCompareLevel;
                minLvl = phaseVCompareLevel;
            end
            ssc_pkg::CASE_VUW: begin
                maxLvl = phaseVCompareLevel;
                midLvl = phaseUCompareLevel;
                minLvl = phaseWCompareLevel;
            end
            ssc_pkg::CASE_VWU: begin
                maxLvl = phaseVCompareLevel;
                midLvl = phaseWCompareLevel;
                minLvl = phaseUCompareLevel;
            end
            default: begin
                maxLvl = phaseWCompareLevel;
                midLvl = phaseVCompareLevel;
                minLvl = phaseUCompareLevel;
            end
        endcase
        upperGap = {1'b0, maxLvl} - {1'b0, midLvl};
        lowerGap = {1'b0, midLvl} - {1'b0, minLvl};
        // dead-time eats into each window, so it is part of the minimum
        readable = (upperGap >= ssc_pkg::MIN_WINDOW)
            && (lowerGap >= ssc_pkg::MIN_WINDOW);
    end

    always_comb begin
        caseNext = caseReg;
        cmpANext = cmpAReg;
        cmpBNext = cmpBReg;
        notReadableNext = notReadableReg;
        armANext = armAReg;
        armBNext = armBReg;
        tagBNext = tagBReg;
        trigANext = 1'b0;
        trigBNext = 1'b0;
        if (periodStart) begin
            caseNext = orderCase;
            cmpANext = midLvl + ssc_pkg::SETTLE_MARGIN;
            cmpBNext = minLvl + ssc_pkg::SETTLE_MARGIN;
            notReadableNext = !readable;
            armANext = 1'b1;
            armBNext = 1'b1;
        end else if (armAReg && (timerCount == cmpAReg)) begin
            trigANext = 1'b1;
            armANext = 1'b0;
            tagBNext = 1'b0;
        end else if (armBReg && (timerCount == cmpBReg)) begin
            // equal compares lose B; such periods are flagged unreadable
            trigBNext = 1'b1;
            armBNext = 1'b0;
            tagBNext = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            caseReg <= ssc_pkg::CASE_UVW;
            cmpAReg <= 16'h0000;
            cmpBReg <= 16'h0000;
            notReadableReg <= 1'b1;
            armAReg <= 1'b0;
            armBReg <= 1'b0;
            trigAReg <= 1'b0;
            trigBReg <= 1'b0;
            tagBReg <= 1'b0;
        end else begin
            caseReg <= caseNext;
            cmpAReg <= cmpANext;
            cmpBReg <= cmpBNext;
            notReadableReg <= notReadableNext;
            armAReg <= armANext;
            armBReg <= armBNext;
            trigAReg <= trigANext;
            trigBReg <= trigBNext;
            tagBReg <= tagBNext;
        end
    end

    // currents must be zero during calibration; the block cannot check that
    always_comb begin
        modeNext = modeReg;
        firstNext = firstReg;
        secondNext = secondReg;
        gotANext = gotAReg;
        gotBNext = gotBReg;
        calibSumNext = calibSumReg;
        calibCntNext = calibCntReg;
        offsetNext = offsetReg;
        commit = carrierTrough && gotAReg && gotBReg && !notReadableReg
            && (modeReg == ssc_pkg::MODE_RUN);
        if (carrierTrough) begin
            gotANext = 1'b0;
            gotBNext = 1'b0;
        end
        if (adcDone) begin
            if (modeReg == ssc_pkg::MODE_CALIB) begin
                calibSumNext = calibSumReg + 16'(adcData);
                calibCntNext = calibCntReg + 4'h1;
                if (calibCntReg == ssc_pkg::CALIB_LAST) begin
                    offsetNext = calibSumNext[15:ssc_pkg::CALIB_LOG2];
                    modeNext = ssc_pkg::MODE_RUN;
                end
            end else if (tagBReg) begin
                secondNext = adcData;
                gotBNext = 1'b1;
            end else begin
                firstNext = adcData;
                gotANext = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            modeReg <= ssc_pkg::MODE_CALIB;
            firstReg <= 12'h000;
            secondReg <= 12'h000;
            gotAReg <= 1'b0;
            gotBReg <= 1'b0;
            calibSumReg <= 16'h0000;
            calibCntReg <= 4'h0;
            offsetReg <= ssc_pkg::ADC_MID;
        end else begin
            modeReg <= modeNext;
            firstReg <= firstNext;
            secondReg <= secondNext;
            gotAReg <= gotANext;
            gotBReg <= gotBNext;
            calibSumReg <= calibSumNext;
            calibCntReg <= calibCntNext;
            offsetReg <= offsetNext;
        end
    end

    always_comb begin
        // above the offset is positive bus current, below is negative
        diffA = $signed({2'b00, firstReg})
            - $signed({2'b00, offsetReg});
        diffB = $signed({2'b00, offsetReg})
            - $signed({2'b00, secondReg});
        diffThird = -(diffA + diffB);
        case (caseReg)
            ssc_pkg::CASE_UVW: begin
                uDiff = diffA;
                wDiff = diffB;
                vDiff = diffThird;
            end
            ssc_pkg::CASE_UWV: begin
                uDiff = diffA;
                vDiff = diffB;
                wDiff = diffThird;
            end
            ssc_pkg::CASE_WUV: begin
                wDiff = diffA;
                vDiff = diffB;
                uDiff = diffThird;
            end
            ssc_pkg::CASE_VUW: begin
                // u from sample A here, although v has the largest duty
                uDiff = diffA;
                wDiff = diffB;
                vDiff = diffThird;
            end
            ssc_pkg::CASE_VWU: begin
                vDiff = diffA;
                uDiff = diffB;
                wDiff = diffThird;
            end
            default: begin
                wDiff = diffA;
                uDiff = diffB;
                vDiff = diffThird;
            end
        endcase
    end

    ssc_current_scale scaleU (
        .clk(clk),
        .srst(srst),
        .load(commit),
        .codeDiff(uDiff),
        .currentMa(phaseUCurrentMa),
        .loaded(currentsValid)
    );

    ssc_current_scale scaleV (
        .clk(clk),
        .srst(srst),
        .load(commit),
        .codeDiff(vDiff),
        .currentMa(phaseVCurrentMa),
        .loaded()
    );

    ssc_current_scale scaleW (
        .clk(clk),
        .srst(srst),
        .load(commit),
        .codeDiff(wDiff),
        .currentMa(phaseWCurrentMa),
        .loaded()
    );

    // the comparator is trusted to pull the line low outside the window
    always_comb begin
        latchNext = (latchReg && !outputDisableClear)
            || !overcurrentDisableInputN || oscillatorStopped;
        forceOff = !overcurrentDisableInputN || oscillatorStopped
            || latchReg;
        busProd = 28'(busVoltageData) * 28'(ssc_pkg::VBUS_FULL_MV);
        busNext = busVoltageDone
            ? busProd[27:ssc_pkg::ADC_FULL_SCALE_LOG2] : busReg;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            latchReg <= 1'b0;
            busReg <= 16'h0000;
        end else begin
            latchReg <= latchNext;
            busReg <= busNext;
        end
    end

    // combinational path: no clock edge between the line and the pins
    assign pwmOutputEnable = forceOff ? 6'h00 : pwmDriveEnable;
    assign outputDisableIrq = latchReg;
    assign sampleTriggerACompare = cmpAReg;
    assign sampleTriggerBCompare = cmpBReg;
    assign adcTriggerA = trigAReg;
    assign adcTriggerB = trigBReg;
    assign shuntResultFirst = firstReg;
    assign shuntResultSecond = secondReg;
    assign caseFlag = caseReg;
    assign notReadable = notReadableReg;
    assign offsetValid = (modeReg == ssc_pkg::MODE_RUN);
    assign shuntOffset = offsetReg;
    assign busVoltageMv = busReg;

    property p_load_uvw;
        @(posedge clk) disable iff (srst)
        periodStart && (orderCase == ssc_pkg::CASE_UVW) |=>
            (cmpAReg == $past(phaseVCompareLevel) + ssc_pkg::SETTLE_MARGIN)
            && (cmpBReg == $past(phaseWCompareLevel)
            + ssc_pkg::SETTLE_MARGIN);
    endproperty
    a_load_uvw: assert property (p_load_uvw)
        else $error("trigger compares wrong for u>v>w");

    property p_load_wvu;
        @(posedge clk) disable iff (srst)
        periodStart && (orderCase == ssc_pkg::CASE_WVU) |=>
            (cmpBReg == $past(phaseUCompareLevel) + ssc_pkg::SETTLE_MARGIN)
            && (caseReg == ssc_pkg::CASE_WVU);
    endproperty
    a_load_wvu: assert property (p_load_wvu)
        else $error("trigger compares wrong for w>v>u");

    property p_fire_a;
        @(posedge clk) disable iff (srst)
        !periodStart && armAReg && (timerCount == cmpAReg) |=>
            adcTriggerA && !armAReg;
    endproperty
    a_fire_a: assert property (p_fire_a)
        else $error("compare match did not start conversion");

    property p_not_readable;
        @(posedge clk) disable iff (srst)
        periodStart && (lowerGap < ssc_pkg::MIN_WINDOW) |=> notReadable;
    endproperty
    a_not_readable: assert property (p_not_readable)
        else $error("short window not flagged");

    sequence s_held;
        !currentsValid && $stable(phaseUCurrentMa)
            && $stable(phaseWCurrentMa);
    endsequence

    property p_hold_unreadable;
        @(posedge clk) disable iff (srst)
        carrierTrough && notReadableReg |=> s_held;
    endproperty
    a_hold_unreadable: assert property (p_hold_unreadable)
        else $error("currents changed in unreadable period");

    property p_disable_now;
        @(posedge clk) disable iff (srst)
        !overcurrentDisableInputN |-> (pwmOutputEnable == 6'h00);
    endproperty
    a_disable_now: assert property (p_disable_now)
        else $error("pwm enables active during overcurrent");

    property p_osc_stop;
        @(posedge clk) disable iff (srst)
        oscillatorStopped |-> (pwmOutputEnable == 6'h00);
    endproperty
    a_osc_stop: assert property (p_osc_stop)
        else $error("pwm enables active with oscillator stopped");

    property p_irq_raise;
        @(posedge clk) disable iff (srst)
        !overcurrentDisableInputN |-> ##1 outputDisableIrq;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("no interrupt after output disable");

    property p_offset_once;
        @(posedge clk) disable iff (srst)
        offsetValid |=> offsetValid && $stable(shuntOffset);
    endproperty
    a_offset_once: assert property (p_offset_once)
        else $error("offset changed after start-up");
endmodule

// [verification/ssc_timer_adc_model.sv]
// PWM timer and hardware-triggered shunt ADC facing the reconstruction block
module ssc_timer_adc_model #(
    parameter int PERIOD = 2048,
    parameter int LAT = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic adcTriggerA,
    input wire logic adcTriggerB,
    input wire logic [11:0] sampleA,
    input wire logic [11:0] sampleB,
    output logic periodStart,
    output logic carrierTrough,
    output logic [15:0] timerCount,
    output logic adcDone,
    output logic [11:0] adcData
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    logic [11:0] pend;
    assign periodStart = (timerCount == 16'h0000) && !srst;
    assign carrierTrough = timerCount == 16'(PERIOD - 1);
    always @(posedge clk) begin
        if (srst) begin
            timerCount <= 16'h0000;
            cnt <= 0;
            adcDone <= 1'b0;
            adcData <= 12'h5A5;
        end else begin
            timerCount <= carrierTrough ? 16'h0000 : timerCount + 16'h0001;
            adcDone <= 1'b0;
            // data lines do not hold a result between conversions
            adcData <= ~adcData;
            if (adcTriggerA || adcTriggerB) begin
                cnt <= LAT;
                pend <= adcTriggerA ? sampleA : sampleB;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end else if (cnt == 1) begin
                cnt <= 0;
                adcDone <= 1'b1;
                adcData <= pend;
            end
        end
    end
endmodule

// [verification/tb_ssc_current_reconstruction.sv]
// self-checking bench for the single-shunt reconstruction block
module tb_ssc_current_reconstruction;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] CF [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10,
        6'h20};
    localparam int RK [6][3] = '{'{2, 1, 0}, '{2, 0, 1}, '{1, 0, 2},
        '{1, 2, 0}, '{0, 2, 1}, '{0, 1, 2}};
    localparam int PA [6] = '{0, 0, 2, 0, 1, 2};
    localparam int PB [6] = '{2, 1, 1, 2, 0, 0};
    localparam int M = ssc_pkg::SETTLE_MARGIN_CYC;
    logic clk = 1'b0;
    logic srst, periodStart, carrierTrough, adcDone, busVoltageDone;
    logic overcurrentDisableInputN, oscillatorStopped, outputDisableClear;
    logic adcTriggerA, adcTriggerB, notReadable, offsetValid;
    logic currentsValid, outputDisableIrq;
    logic [15:0] timerCount, phaseUCompareLevel, phaseVCompareLevel;
    logic [15:0] phaseWCompareLevel, sampleTriggerACompare;
    logic [15:0] sampleTriggerBCompare, busVoltageMv;
    logic [11:0] adcData, busVoltageData, shuntResultFirst;
    logic [11:0] shuntResultSecond, shuntOffset, sampleA, sampleB, cal;
    logic [11:0] ra, rb;
    logic [5:0] pwmDriveEnable, caseFlag, pwmOutputEnable;
    logic signed [15:0] phaseUCurrentMa, phaseVCurrentMa, phaseWCurrentMa;
    logic [15:0] lv [3];
    logic [47:0] expQ [$];
    logic [47:0] lastCur = 48'h0;
    logic [31:0] seed = 32'h00011715;
    bit live = 1'b0;
    bit arm = 1'b0;
    int errTotal = 0;
    int totalChecks = 0;

    always #4 clk = ~clk;

    ssc_current_reconstruction i_ssc_current_reconstruction (.clk, .srst,
        .periodStart, .carrierTrough, .timerCount, .phaseUCompareLevel,
        .phaseVCompareLevel, .phaseWCompareLevel, .adcDone, .adcData,
        .busVoltageDone, .busVoltageData, .pwmDriveEnable,
        .overcurrentDisableInputN, .oscillatorStopped, .outputDisableClear,
        .sampleTriggerACompare, .sampleTriggerBCompare, .adcTriggerA,
        .adcTriggerB, .shuntResultFirst, .shuntResultSecond, .caseFlag,
        .notReadable, .offsetValid, .shuntOffset, .phaseUCurrentMa,
        .phaseVCurrentMa, .phaseWCurrentMa, .currentsValid, .busVoltageMv,
        .pwmOutputEnable, .outputDisableIrq);

    ssc_timer_adc_model #(.PERIOD(2048), .LAT(20)) i_ssc_timer_adc_model (
        .clk, .srst, .adcTriggerA, .adcTriggerB, .sampleA, .sampleB,
        .periodStart, .carrierTrough, .timerCount, .adcDone, .adcData);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // floor division by the full-scale count, as the hardware does
    function automatic logic [15:0] ma(input int d);
        return 16'((d * 10000) >>> 12);
    endfunction

    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        totalChecks++;
        if (g !== e) begin
            errTotal++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic set_levels(input int k);
        for (int i = 0; i < 3; i++)
            lv[i] = 16'(300 + 600 * RK[k][i] + (rnd() & 32'h3F));
    endtask

    task automatic run_period(input int k, input logic [11:0] a,
            input logic [11:0] b, input bit rd);
        int mid;
        int lo;
        int df [3];
        do @(negedge clk); while (carrierTrough !== 1'b1);
        phaseUCompareLevel = lv[0];
        phaseVCompareLevel = lv[1];
        phaseWCompareLevel = lv[2];
        sampleA = a;
        sampleB = b;
        do @(negedge clk); while (periodStart !== 1'b1);
        @(negedge clk);
        live = arm;
        chk(notReadable, !rd);
        if (rd) begin
            for (int i = 0; i < 3; i++) begin
                if (RK[k][i] == 1) mid = lv[i];
                if (RK[k][i] == 0) lo = lv[i];
            end
            chk(sampleTriggerACompare, mid + M);
            chk(sampleTriggerBCompare, lo + M);
            chk(caseFlag, CF[k]);
            df[PA[k]] = int'(a) - int'(cal);
            df[PB[k]] = int'(cal) - int'(b);
            df[3 - PA[k] - PB[k]] = -(df[PA[k]] + df[PB[k]]);
            if (live) expQ.push_back({ma(df[0]), ma(df[1]), ma(df[2])});
        end
    endtask

    // every commit pulse seen while live is set must match the oldest expectation
    always @(negedge clk) begin
        if (live && currentsValid === 1'b1) begin
            if (expQ.size() == 0) begin
                chk(48'h1, 48'h0);
            end else begin
                lastCur = expQ.pop_front();
                chk({phaseUCurrentMa, phaseVCurrentMa, phaseWCurrentMa},
                    lastCur);
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        errTotal++;
        stop_test();
    end

    initial begin
        srst = 1'b1;
        cal = 12'h7C0 + 12'(rnd() & 32'h3F);
        sampleA = cal;
        sampleB = cal;
        phaseUCompareLevel = 16'h0000;
        phaseVCompareLevel = 16'h0000;
        phaseWCompareLevel = 16'h0000;
        busVoltageDone = 1'b0;
        busVoltageData = 12'h000;
        pwmDriveEnable = 6'h3F;
        overcurrentDisableInputN = 1'b1;
        oscillatorStopped = 1'b0;
        outputDisableClear = 1'b0;
        repeat (4) @(negedge clk);
        chk({caseFlag, notReadable, offsetValid}, {6'h01, 2'b10});
        chk(shuntOffset, ssc_pkg::ADC_MID);
        srst = 1'b0;
        for (int p = 0; p < 9; p++) begin
            set_levels(0);
            run_period(0, cal, cal, 1'b1);
        end
        chk({offsetValid, shuntOffset}, {1'b1, cal});
        $display("test offset calibration done");
        arm = 1'b1;
        for (int p = 0; p < 12; p++) begin
            set_levels(p % 6);
            ra = (p == 0) ? 12'hFFF : 12'(rnd());
            rb = (p == 0) ? 12'h000 : 12'(rnd());
            run_period(p % 6, ra, rb, 1'b1);
        end
        $display("test duty orderings done");
        lv = '{16'h03E8, 16'h0384, 16'h0064};
        run_period(0, 12'h123, 12'h456, 1'b0);
        do @(negedge clk); while (carrierTrough !== 1'b1);
        repeat (2) @(negedge clk);
        chk({phaseUCurrentMa, phaseVCurrentMa, phaseWCurrentMa},
            lastCur);
        chk({shuntResultFirst, shuntResultSecond}, {12'h123, 12'h456});
        $display("test unreadable period done");
        for (int i = 0; i < 3; i++) begin
            busVoltageData = (i == 0) ? 12'hFFF : 12'(rnd());
            busVoltageDone = 1'b1;
            @(negedge clk);
            busVoltageDone = 1'b0;
            repeat (2) @(negedge clk);
            chk(busVoltageMv, (int'(busVoltageData) * 50000) >>> 12);
        end
        $display("test bus voltage done");
        pwmDriveEnable = 6'(rnd()) | 6'h01;
        for (int c = 0; c < 2; c++) begin
            @(negedge clk);
            overcurrentDisableInputN = (c == 1);
            oscillatorStopped = (c == 1);
            #1;
            chk(pwmOutputEnable, 6'h00);
            @(negedge clk);
            chk(outputDisableIrq, 1'b1);
            overcurrentDisableInputN = 1'b1;
            oscillatorStopped = 1'b0;
            @(negedge clk);
            chk(pwmOutputEnable, 6'h00);
            outputDisableClear = 1'b1;
            @(negedge clk);
            outputDisableClear = 1'b0;
            #1;
            chk({outputDisableIrq, pwmOutputEnable},
                {1'b0, pwmDriveEnable});
        end
        $display("test output disable done");
        chk(48'(expQ.size()), 48'h0);
        stop_test();
    end
endmodule
